// ### src/dsmu_map.vh
`ifndef DSMU_MAP_VH
`define DSMU_MAP_VH

// register byte offsets
`define DSMU_OFF_CTRL 4'h0
`define DSMU_OFF_OPA 4'h4
`define DSMU_OFF_OPB 4'h8
`define DSMU_OFF_OPC 4'hc
`define DSMU_OFF_RESULT 4'h0
`define DSMU_OFF_STATUS 4'h4
`define DSMU_OFF_FLAGS 4'h8
// page select: address bit 4 picks operand page (0) or result page (1)
`define DSMU_PAGE_BIT 4

// control field positions
`define DSMU_CTRL_OP_LSB 0
`define DSMU_CTRL_ROUND 4
`define DSMU_CTRL_POS_LSB 5
`define DSMU_CTRL_COND_LSB 10
`define DSMU_CTRL_GO 31
`define DSMU_CTRL_MASK 32'h00003fff

// status field positions
`define DSMU_ST_STICKY 0
`define DSMU_ST_BUSY 1
`define DSMU_ST_SKIP 2

// reset values
`define DSMU_RST_WORD 32'h00000000
`define DSMU_RST_NZCV 4'h0

// operation codes
`define DSMU_OP_MHA 4'h0
`define DSMU_OP_MHS 4'h1
`define DSMU_OP_DSC 4'h2
`define DSMU_OP_DUC 4'h3
`define DSMU_OP_SAW 4'h4
`define DSMU_OP_SSW 4'h5
`define DSMU_OP_SADH 4'h6
`define DSMU_OP_SSDH 4'h7
`define DSMU_OP_SAQB 4'h8
`define DSMU_OP_SSQB 4'h9

// rounding constant added to the full product
`define DSMU_ROUND_K 64'h0000000080000000

// bus responses
`define DSMU_RESP_OK 2'h0
`define DSMU_RESP_SLVERR 2'h2

`endif

// ### src/dsmu_mulhi.v
`timescale 1ns/1ps
`default_nettype none

module dsmu_mulhi #(
	parameter WIDTH = 32
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] multiplicand_one,
	input wire [WIDTH-1:0] multiplier_two,
	input wire [WIDTH-1:0] addend_source,
	input wire round,
	input wire subtract,
	output reg [WIDTH-1:0] result_reg
);
`include "dsmu_map.vh"

	wire signed [2*WIDTH-1:0] prod;
	wire [2*WIDTH-1:0] prod_rnd;
	wire [WIDTH-1:0] high_word;
	reg [WIDTH-1:0] result_next;

	// signed full product, optional rounding before the high word is taken
	assign prod = $signed(multiplicand_one) * $signed(multiplier_two);
	assign prod_rnd = prod + (round ? `DSMU_ROUND_K : 64'h0);
	assign high_word = prod_rnd[2*WIDTH-1:WIDTH];

	// accumulate or subtract against the third operand
	always @* begin
		if (subtract)
			result_next = addend_source - high_word;
		else
			result_next = high_word + addend_source;
	end

	// registered to break the long multiplier path
	always @(posedge aclk) begin
		if (!aresetn)
			result_reg <= `DSMU_RST_WORD;
		else
			result_reg <= result_next;
	end

endmodule // dsmu_mulhi
`default_nettype wire

// ### src/dsmu_top.v
// How it works
// - high multiply: product top word plus addend
// - high multiply-subtract: addend minus top word
// - rounding adds 0x80000000 before taking top
// - multiplies leave condition flags untouched
// - signed clamp halves to n bits, 1-16
// - unsigned clamp halves to selected range
// - unsigned clamp position accepts 0 to 15
// - either clamp saturating sets sticky flag
// - saturated means written differs from exact
// - add/sub lanes clamp to signed lane range
// - word add: signed sum, clamped
// - word subtract: first minus second, clamped
// - four byte lanes add or subtract, clamped
// - two halfword lanes add or subtract, clamped
// - word add/sub saturation sets sticky flag
// - lane add/sub never touch sticky flag
// - only status write or reset clears sticky flag
// - sticky flag read only through status read
// - condition code gates whether op takes effect
`timescale 1ns/1ps
`default_nettype none

module dsmu_top (
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
`include "dsmu_map.vh"

	localparam ST_IDLE = 3'b001;
	localparam ST_CALC = 3'b010;
	localparam ST_WRITE = 3'b100;

	////////////////////////////////////////////////////////////////////////////
	// functions

	// byte-strobe merge of a write into a stored word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] neu;
		input [3:0] strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					merge[8*k +: 8] = neu[8*k +: 8];
		end
	endfunction

	// signed clamp to n bits; top bit of result flags a clamp
	function [32:0] sat_s;
		input signed [33:0] v;
		input [5:0] n;
		reg signed [33:0] hi;
		reg signed [33:0] lo;
		begin
			hi = $signed(34'd1 << (n - 6'd1)) - 34'sd1;
			lo = -hi - 34'sd1;
			if (v > hi)
				sat_s = {1'b1, hi[31:0]};
			else if (v < lo)
				sat_s = {1'b1, lo[31:0]};
			else
				sat_s = {1'b0, v[31:0]};
		end
	endfunction

	// unsigned clamp to n bits; negative input goes to zero
	function [32:0] sat_u;
		input signed [33:0] v;
		input [4:0] n;
		reg signed [33:0] hi;
		begin
			hi = $signed(34'd1 << n) - 34'sd1;
			if (v < 34'sd0)
				sat_u = {1'b1, 32'h00000000};
			else if (v > hi)
				sat_u = {1'b1, hi[31:0]};
			else
				sat_u = {1'b0, v[31:0]};
		end
	endfunction

	// condition code against n z c v
	function cond_ok;
		input [3:0] cc;
		input [3:0] f;
		begin
			case (cc)
				4'h0: cond_ok = f[2];
				4'h1: cond_ok = !f[2];
				4'h2: cond_ok = f[1];
				4'h3: cond_ok = !f[1];
				4'h4: cond_ok = f[3];
				4'h5: cond_ok = !f[3];
				4'h6: cond_ok = f[0];
				4'h7: cond_ok = !f[0];
				4'h8: cond_ok = f[1] && !f[2];
				4'h9: cond_ok = !f[1] || f[2];
				4'ha: cond_ok = f[3] == f[0];
				4'hb: cond_ok = f[3] != f[0];
				4'hc: cond_ok = !f[2] && (f[3] == f[0]);
				4'hd: cond_ok = f[2] || (f[3] != f[0]);
				default: cond_ok = 1'b1;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	reg [31:0] ctrl_reg;
	reg [31:0] opa_reg;
	reg [31:0] opb_reg;
	reg [31:0] opc_reg;
	reg [31:0] result_reg;
	reg [3:0] nzcv_reg;
	reg sticky_reg;
	reg skip_reg;
	reg [2:0] state_reg;
	reg [3:0] op_reg;
	reg [4:0] pos_reg;
	reg [3:0] cond_reg;
	reg [4:0] awaddr_reg;
	reg aw_full_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg w_full_reg;

	wire [31:0] mul_result;
	wire do_write;
	wire wr_page;
	wire [3:0] wr_off;
	wire [31:0] ctrl_merged;
	wire go;
	wire status_wr;

	reg [31:0] res_next;
	reg sat_hit;
	reg sets_sticky;
	reg signed [33:0] lane;
	reg [32:0] sr;
	reg [5:0] n_s;
	reg [4:0] n_u;
	reg [31:0] rd_mux;
	reg rd_err;
	integer i;

	////////////////////////////////////////////////////////////////////////////
	// high-word multiplier, registered one cycle
	dsmu_mulhi #(
		.WIDTH(32)
	) u_mulhi (
		.aclk(aclk),
		.aresetn(aresetn),
		.multiplicand_one(opa_reg),
		.multiplier_two(opb_reg),
		.addend_source(opc_reg),
		.round(ctrl_reg[`DSMU_CTRL_ROUND]),
		.subtract(op_reg == `DSMU_OP_MHS),
		.result_reg(mul_result)
	);

	////////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
	assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign wr_page = awaddr_reg[`DSMU_PAGE_BIT];
	assign wr_off = awaddr_reg[3:0];
	assign ctrl_merged = merge(ctrl_reg, wdata_reg, wstrb_reg);
	assign go = do_write && !wr_page && wr_off == `DSMU_OFF_CTRL
		&& ctrl_merged[`DSMU_CTRL_GO] && state_reg == ST_IDLE;
	assign status_wr = do_write && wr_page && wr_off == `DSMU_OFF_STATUS;

	// write holding registers and response
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= 5'h00;
			wdata_reg <= `DSMU_RST_WORD;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DSMU_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_reg[1:0] != 2'h0 || (wr_page && wr_off == `DSMU_OFF_RESULT)
					|| wr_off == 4'hc && wr_page)
					s_axi_bresp <= `DSMU_RESP_SLVERR;
				else
					s_axi_bresp <= `DSMU_RESP_OK;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// software-visible registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `DSMU_RST_WORD;
			opa_reg <= `DSMU_RST_WORD;
			opb_reg <= `DSMU_RST_WORD;
			opc_reg <= `DSMU_RST_WORD;
			nzcv_reg <= `DSMU_RST_NZCV;
		end else if (do_write && awaddr_reg[1:0] == 2'h0) begin
			if (!wr_page) begin
				case (wr_off)
					`DSMU_OFF_CTRL: ctrl_reg <= ctrl_merged & `DSMU_CTRL_MASK;
					`DSMU_OFF_OPA: opa_reg <= merge(opa_reg, wdata_reg, wstrb_reg);
					`DSMU_OFF_OPB: opb_reg <= merge(opb_reg, wdata_reg, wstrb_reg);
					`DSMU_OFF_OPC: opc_reg <= merge(opc_reg, wdata_reg, wstrb_reg);
					default: ctrl_reg <= ctrl_reg;
				endcase
			end else if (wr_off == `DSMU_OFF_FLAGS && wstrb_reg[0]) begin
				nzcv_reg <= wdata_reg[3:0]; // only software moves these
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read channel, data from a register
	assign s_axi_arready = !s_axi_rvalid;

	// read decode
	always @* begin
		rd_mux = `DSMU_RST_WORD;
		rd_err = s_axi_araddr[1:0] != 2'h0;
		if (!s_axi_araddr[`DSMU_PAGE_BIT]) begin
			case (s_axi_araddr[3:0])
				`DSMU_OFF_CTRL: rd_mux = ctrl_reg;
				`DSMU_OFF_OPA: rd_mux = opa_reg;
				`DSMU_OFF_OPB: rd_mux = opb_reg;
				`DSMU_OFF_OPC: rd_mux = opc_reg;
				default: rd_err = 1'b1;
			endcase
		end else begin
			case (s_axi_araddr[3:0])
				`DSMU_OFF_RESULT: rd_mux = result_reg;
				`DSMU_OFF_STATUS: rd_mux = {29'h0, skip_reg, state_reg != ST_IDLE,
					sticky_reg};
				`DSMU_OFF_FLAGS: rd_mux = {28'h0, nzcv_reg};
				default: rd_err = 1'b1;
			endcase
		end
	end

	// read response
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `DSMU_RST_WORD;
			s_axi_rresp <= `DSMU_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_err ? `DSMU_RST_WORD : rd_mux;
			s_axi_rresp <= rd_err ? `DSMU_RESP_SLVERR : `DSMU_RESP_OK;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// datapath: result and saturation for the latched operation
	always @* begin
		res_next = result_reg;
		sat_hit = 1'b0;
		sets_sticky = 1'b0;
		lane = 34'sd0;
		sr = 33'h0;
		i = 0;
		// out-of-range positions fall back to the widest legal clamp
		n_s = (pos_reg == 5'd0 || pos_reg > 5'd16) ? 6'd16 : {1'b0, pos_reg};
		n_u = (pos_reg > 5'd15) ? 5'd15 : pos_reg;
		case (op_reg)
			`DSMU_OP_MHA, `DSMU_OP_MHS: begin
				res_next = mul_result;
			end
			`DSMU_OP_DSC: begin
				sets_sticky = 1'b1;
				for (i = 0; i < 2; i = i + 1) begin
					lane = {{18{opb_reg[16*i+15]}}, opb_reg[16*i +: 16]};
					sr = sat_s(lane, n_s);
					res_next[16*i +: 16] = sr[15:0];
					sat_hit = sat_hit | sr[32];
				end
			end
			`DSMU_OP_DUC: begin
				sets_sticky = 1'b1;
				for (i = 0; i < 2; i = i + 1) begin
					lane = {{18{opb_reg[16*i+15]}}, opb_reg[16*i +: 16]};
					sr = sat_u(lane, n_u);
					res_next[16*i +: 16] = sr[15:0];
					sat_hit = sat_hit | sr[32];
				end
			end
			`DSMU_OP_SAW, `DSMU_OP_SSW: begin
				sets_sticky = 1'b1;
				if (op_reg == `DSMU_OP_SAW)
					lane = {{2{opa_reg[31]}}, opa_reg} + {{2{opb_reg[31]}}, opb_reg};
				else
					lane = {{2{opa_reg[31]}}, opa_reg} - {{2{opb_reg[31]}}, opb_reg};
				sr = sat_s(lane, 6'd32);
				res_next = sr[31:0];
				sat_hit = sr[32];
			end
			`DSMU_OP_SADH, `DSMU_OP_SSDH: begin
				for (i = 0; i < 2; i = i + 1) begin
					if (op_reg == `DSMU_OP_SADH)
						lane = {{18{opa_reg[16*i+15]}}, opa_reg[16*i +: 16]}
							+ {{18{opb_reg[16*i+15]}}, opb_reg[16*i +: 16]};
					else
						lane = {{18{opa_reg[16*i+15]}}, opa_reg[16*i +: 16]}
							- {{18{opb_reg[16*i+15]}}, opb_reg[16*i +: 16]};
					sr = sat_s(lane, 6'd16);
					res_next[16*i +: 16] = sr[15:0];
				end
			end
			`DSMU_OP_SAQB, `DSMU_OP_SSQB: begin
				for (i = 0; i < 4; i = i + 1) begin
					if (op_reg == `DSMU_OP_SAQB)
						lane = {{26{opa_reg[8*i+7]}}, opa_reg[8*i +: 8]}
							+ {{26{opb_reg[8*i+7]}}, opb_reg[8*i +: 8]};
					else
						lane = {{26{opa_reg[8*i+7]}}, opa_reg[8*i +: 8]}
							- {{26{opb_reg[8*i+7]}}, opb_reg[8*i +: 8]};
					sr = sat_s(lane, 6'd8);
					res_next[8*i +: 8] = sr[7:0];
				end
			end
			default: res_next = result_reg;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// operation sequencer: idle, multiplier settle, write back
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			op_reg <= `DSMU_OP_MHA;
			pos_reg <= 5'h00;
			cond_reg <= 4'h0;
			result_reg <= `DSMU_RST_WORD;
			skip_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (go) begin
						op_reg <= ctrl_merged[`DSMU_CTRL_OP_LSB +: 4];
						pos_reg <= ctrl_merged[`DSMU_CTRL_POS_LSB +: 5];
						cond_reg <= ctrl_merged[`DSMU_CTRL_COND_LSB +: 4];
						state_reg <= ST_CALC;
					end
				end
				ST_CALC: state_reg <= ST_WRITE;
				ST_WRITE: begin
					skip_reg <= !cond_ok(cond_reg, nzcv_reg);
					if (cond_ok(cond_reg, nzcv_reg))
						result_reg <= res_next;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// sticky saturation flag: status write loads it, a saturation event wins
	always @(posedge aclk) begin
		if (!aresetn)
			sticky_reg <= 1'b0;
		else if (state_reg == ST_WRITE && cond_ok(cond_reg, nzcv_reg)
			&& sets_sticky && sat_hit)
			sticky_reg <= 1'b1;
		else if (status_wr && wstrb_reg[0])
			sticky_reg <= wdata_reg[`DSMU_ST_STICKY];
	end

endmodule // dsmu_top
`default_nettype wire

// ### sim/dsmu_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsmu_map.vh"
module dsmu_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////
	// both halves of a write taken at one edge
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_ans; s_wr_take |-> ##2 s_axi_bvalid; endproperty
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_ar_rdy; s_axi_arready == !s_axi_rvalid; endproperty
	property p_aw_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	property p_rd_ans; s_rd_take |=> s_axi_rvalid; endproperty
	property p_b_rel; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_r_rel; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	property p_miss;
		s_rd_take ##0 (s_axi_araddr[4:2] == 3'h7 || s_axi_araddr[1:0] != 2'h0)
			|=> s_axi_rresp == `DSMU_RESP_SLVERR && s_axi_rdata == 32'h00000000;
	endproperty
	////////////////////////////////////////////////////////////////
	a_wr_ans: assert property (p_wr_ans) else $error("write answer not on time");
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
	a_ar_rdy: assert property (p_ar_rdy) else $error("read ready wrong");
	a_aw_blk: assert property (p_aw_blk) else $error("write taken while answer pending");
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	a_b_rel: assert property (p_b_rel) else $error("write answer not released");
	a_r_rel: assert property (p_r_rel) else $error("read answer not released");
	a_miss: assert property (p_miss) else $error("unmapped read not refused");
endmodule // dsmu_checker
bind dsmu_top dsmu_checker chk_i (.*);
`default_nettype wire

// ### sim/dsmu_master.sv
`timescale 1ns/1ps
`default_nettype none
module dsmu_master (
	input wire logic aclk,
	output var logic [4:0] awaddr,
	output var logic awvalid,
	input wire logic awready,
	output var logic [31:0] wdata,
	output var logic [3:0] wstrb,
	output var logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output var logic bready,
	output var logic [4:0] araddr,
	output var logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output var logic rready
);
	// idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
	end
	////////////////////////////////////////////////////////////////
	// operands are plain data words, never core pointers
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		// let an edge pass so a following call never reassigns bready at once
		@(posedge aclk);
	endtask
	// one read, held until the answer edge
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		// let an edge pass so a following call never reassigns rready at once
		@(posedge aclk);
	endtask
endmodule // dsmu_master
`default_nettype wire

// ### sim/dsmu_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsmu_map.vh"
module dsmu_top_bench;
	localparam logic [4:0] A_CTRL = {1'b0, `DSMU_OFF_CTRL};
	localparam logic [4:0] A_OPA = {1'b0, `DSMU_OFF_OPA};
	localparam logic [4:0] A_OPB = {1'b0, `DSMU_OFF_OPB};
	localparam logic [4:0] A_OPC = {1'b0, `DSMU_OFF_OPC};
	localparam logic [4:0] A_RES = {1'b1, `DSMU_OFF_RESULT};
	localparam logic [4:0] A_STAT = {1'b1, `DSMU_OFF_STATUS};
	localparam logic [4:0] A_FLG = {1'b1, `DSMU_OFF_FLAGS};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	wire logic [4:0] awaddr, araddr;
	wire logic [31:0] wdata, rdata;
	wire logic [3:0] wstrb;
	wire logic [1:0] bresp, rresp;
	wire logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	integer n_fail = 0;
	integer n_tests = 0;
	logic [31:0] exp_r = 32'h0, got;
	logic [1:0] rs;
	logic exp_q = 1'b0, sat_hit;
	always #20 aclk = ~aclk;
	dsmu_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	dsmu_master m (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// clamp to a range, noting any change
	function automatic logic signed [33:0] clamp(input logic signed [33:0] v, lo, hi);
		clamp = v < lo ? lo : (v > hi ? hi : v);
		if (clamp != v) sat_hit = 1'b1;
	endfunction
	// reference result of one operation
	function automatic logic [31:0] model(input logic [3:0] op, input logic rnd,
		input logic [4:0] n, input logic [31:0] a, b, c);
		logic signed [63:0] p;
		logic signed [33:0] lo, hi;
		logic [31:0] r;
		p = $signed(a) * $signed(b) + (rnd ? 64'sh80000000 : 64'sh0);
		r = exp_r;
		case (op)
			4'h0: r = p[63:32] + c;
			4'h1: r = c - p[63:32];
			4'h2, 4'h3: for (int i = 0; i < 2; i++) begin
				lo = op == 4'h2 ? -(34'sd1 <<< (n - 1)) : 34'sd0;
				hi = op == 4'h2 ? (34'sd1 <<< (n - 1)) - 1 : (34'sd1 <<< n) - 1;
				r[16*i+:16] = 16'(clamp($signed(b[16*i+:16]), lo, hi));
			end
			// sums widened first so a lane overflow cannot wrap before the clamp
			4'h4, 4'h5: r = 32'(clamp(op == 4'h4 ? 34'($signed(a)) + 34'($signed(b)) :
				34'($signed(a)) - 34'($signed(b)), -(34'sd1 <<< 31), (34'sd1 <<< 31) - 1));
			4'h6, 4'h7: for (int i = 0; i < 2; i++)
				r[16*i+:16] = 16'(clamp(op == 4'h6 ?
					34'($signed(a[16*i+:16])) + 34'($signed(b[16*i+:16])) :
					34'($signed(a[16*i+:16])) - 34'($signed(b[16*i+:16])),
					-34'sd32768, 34'sd32767));
			4'h8, 4'h9: for (int i = 0; i < 4; i++)
				r[8*i+:8] = 8'(clamp(op == 4'h8 ?
					34'($signed(a[8*i+:8])) + 34'($signed(b[8*i+:8])) :
					34'($signed(a[8*i+:8])) - 34'($signed(b[8*i+:8])),
					-34'sd128, 34'sd127));
			default: r = exp_r;
		endcase
		return r;
	endfunction
	// load operands, start, then check status and result
	task automatic run(input logic [3:0] op, input logic rnd, input logic [4:0] n,
		input logic [3:0] cc, input logic tk, input logic [31:0] a, b, c);
		m.wr(A_OPA, a, rs);
		m.wr(A_OPB, b, rs);
		m.wr(A_OPC, c, rs);
		m.wr(A_CTRL, {1'b1, 17'h0, cc, n, rnd, op}, rs);
		chk({30'h0, rs}, {30'h0, `DSMU_RESP_OK});
		sat_hit = 1'b0;
		if (tk) exp_r = model(op, rnd, n, a, b, c);
		exp_q = exp_q | (tk & sat_hit & (op >= 4'h2) & (op <= 4'h5));
		// wait out the busy bit; only the watchdog bounds this
		do begin
			m.rd(A_STAT, got, rs);
		end while (got[1]);
		chk(got, {29'h0, !tk, 1'b0, exp_q});
		m.rd(A_RES, got, rs);
		chk(got, exp_r);
	endtask
	task automatic clear_q();
		m.wr(A_STAT, 32'h0, rs);
		exp_q = 1'b0;
		m.rd(A_STAT, got, rs);
		chk(got, 32'h0);
	endtask
	task complete_run();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		#200000;
		n_fail++;
		complete_run();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		m.rd(A_RES, got, rs);
		chk(got, `DSMU_RST_WORD);
		m.wr(A_FLG, 32'h4, rs);
		run(4'h0, 0, 0, 4'hf, 1, 32'h40000000, 32'h4, 32'h5);
		run(4'h0, 0, 0, 4'hf, 1, 32'h00010000, 32'h8000, 32'h0);
		run(4'h0, 1, 0, 4'hf, 1, 32'h00010000, 32'h8000, 32'h0);
		run(4'h1, 1, 0, 4'hf, 1, 32'hfffe0000, 32'h8000, 32'h10);
		m.rd(A_FLG, got, rs);
		chk(got, 32'h4);
		run(4'h2, 0, 9, 4'hf, 1, 32'h0, 32'h0100fe00, 32'h0);
		clear_q();
		run(4'h2, 0, 16, 4'hf, 1, 32'h0, 32'h80007fff, 32'h0);
		run(4'h2, 0, 1, 4'hf, 1, 32'h0, 32'h00010000, 32'h0);
		run(4'h3, 0, 0, 4'hf, 1, 32'h0, 32'h0001ffff, 32'h0);
		run(4'h3, 0, 15, 4'hf, 1, 32'h0, 32'h7fff8000, 32'h0);
		clear_q();
		run(4'h6, 0, 0, 4'hf, 1, 32'h7fff8000, 32'h00018000, 32'h0);
		run(4'h7, 0, 0, 4'hf, 1, 32'h80007fff, 32'h0001ffff, 32'h0);
		run(4'h8, 0, 0, 4'hf, 1, 32'h7f80017f, 32'h01800101, 32'h0);
		run(4'h9, 0, 0, 4'hf, 1, 32'h807f0010, 32'h01ff0020, 32'h0);
		run(4'h4, 0, 0, 4'hf, 1, 32'h7fffffff, 32'h1, 32'h0);
		clear_q();
		run(4'h5, 0, 0, 4'hf, 1, 32'h80000000, 32'h1, 32'h0);
		run(4'h4, 0, 0, 4'hf, 1, 32'h1, 32'h2, 32'h0);
		run(4'h4, 0, 0, 4'h1, 0, 32'h5, 32'h6, 32'h0);
		run(4'h4, 0, 0, 4'h0, 1, 32'h5, 32'h6, 32'h0);
		// zero flag set: higher-unsigned fails, less-or-equal passes
		run(4'h4, 0, 0, 4'h8, 0, 32'h7, 32'h7, 32'h0);
		run(4'h4, 0, 0, 4'hd, 1, 32'h7, 32'h7, 32'h0);
		m.wr(A_RES, 32'h1, rs);
		chk({30'h0, rs}, {30'h0, `DSMU_RESP_SLVERR});
		m.rd(5'h1c, got, rs);
		chk({30'h0, rs}, {30'h0, `DSMU_RESP_SLVERR});
		chk(got, 32'h0);
		complete_run();
	end
endmodule // dsmu_top_bench
`default_nettype wire
